// File: hdl/uhr_core.v
/*
 * Holding registers, transmit shift path, receive path, interrupt
 * enable mask and line status for a single-channel uart.
 * Assumes an 8-bit host bus with one-cycle read and write strobes,
 * synchronous inputs, and fifo enable / trigger from the fifo control.
 */
// What this block does
// - 8-bit tx holding register feeds tx shifter
// - holding write taken when holding has a free slot
// - empty flag sets on shifter load or idle
// - fifo mode: empty flag shows free slot
// - holding read returns and removes oldest byte
// - falling edge, 16x count, mid-bit low check
// - mask gates seven sources onto interrupt pin
// - mask bit 7: cts rising edge interrupts
// - mask bit 6: rts rising edge interrupts
// - mask bit 5: received xoff interrupts
// - mask bit 4 permits sleep mode
// - mask bit 3: modem status change interrupts
// - mask bit 2: character arrival raises line interrupt
// - mask bit 1: holding empty raises tx interrupt
// - mask bit 0: fifo at trigger interrupts
// - all mask bits reset to zero
// - source status follows trigger, clears with interrupt
// - data ready while receive fifo holds bytes
// - status bits: errors, tx empty, all empty, fifo error
// - these registers need divisor latch enable zero
`include "uhr_map.vh"

module uhr_core (
    input  wire       clk,         // system clock, 25 MHz
    input  wire       resetn,      // sync reset, active low
    input  wire [2:0] addr,        // register address
    input  wire [7:0] wdata,       // host write data
    input  wire       wr_stb,      // one-cycle write strobe
    input  wire       rd_stb,      // one-cycle read strobe
    output reg  [7:0] rdata,       // read data, valid cycle after rd_stb
    input  wire       fifo_en,     // fifo mode enable
    input  wire [5:0] rx_trigger,  // receive trigger level
    input  wire       rx_flush,    // receive fifo reset pulse
    input  wire       tx_flush,    // transmit fifo reset pulse
    input  wire       tick16,      // 16x bit-rate enable
    input  wire       sin,         // serial input
    output reg        sout,        // serial output
    input  wire       cts,         // clear-to-send level
    input  wire       rts,         // request-to-send level
    input  wire       xoff_seen,   // pulse: xoff received
    input  wire       modem_chg,   // pulse: modem status changed
    output reg        irq,         // host interrupt, active high
    output reg        sleep_ok,    // sleep mode permitted
    output reg        rx_ready     // receive data present
);

    reg  [7:0] irq_mask_reg;
    reg  [7:0] line_format_reg;
    reg  [3:0] tx_state_reg;
    reg  [3:0] tx_cnt_reg;
    reg  [3:0] tx_bit_reg;
    reg  [9:0] tx_shifter;
    reg        cts_last_reg;
    reg        rts_last_reg;
    reg        cts_evt_reg;
    reg        rts_evt_reg;
    reg        xoff_evt_reg;
    reg        modem_evt_reg;
    reg        rls_evt_reg;
    reg        oe_reg;
    reg        fe_reg;
    reg        bi_reg;
    reg  [7:0] rx_hold_reg;
    reg  [7:0] irq_src;
    wire       rdata_next_sel;
    wire       gen_sel;
    wire       hold_wr;
    wire       hold_rd;
    wire       tx_in_ready;
    wire [7:0] txf_data;
    wire       txf_valid;
    wire       txf_pop;
    wire [5:0] txf_level;
    wire [7:0] rxc_data;
    wire       rxc_valid;
    wire       rxc_fe;
    wire       rxc_bi;
    wire       rxc_ready;
    wire [7:0] rxf_data;
    wire       rxf_valid;
    wire [5:0] rxf_level;
    wire [7:0] skid_data;
    wire       skid_valid;
    wire       skid_ready;
    wire       thr_empty;
    wire       tx_all_empty;
    wire       trig_hit;
    wire       cts_rise;
    wire       rts_rise;
    wire [7:0] line_status_reg;
    wire [5:0] tx_cap;
    wire [5:0] rx_cap;

    localparam [3:0] TX_IDLE  = 4'b0001;
    localparam [3:0] TX_SHIFT = 4'b0010;
    localparam [3:0] TX_LOAD  = 4'b0100;
    localparam [3:0] TX_SPARE = 4'b1000;

    ////////////////////////////////////////////////////////////////////////
    // decode: general set only while divisor latch enable is low
    assign gen_sel = !line_format_reg[`UHR_FMT_DLAB];
    assign hold_wr = wr_stb && gen_sel && (addr == `UHR_ADDR_HOLD);
    assign hold_rd = rd_stb && gen_sel && (addr == `UHR_ADDR_HOLD);
    // non-fifo mode behaves as a single holding slot
    assign tx_cap  = fifo_en ? 6'h20 : 6'h01;
    assign rx_cap  = fifo_en ? 6'h20 : 6'h01;

    ////////////////////////////////////////////////////////////////////////
    // transmit holding fifo; a write to a full holding is dropped
    uhr_fifo #(.DEPTH(`UHR_FIFO_DEPTH), .AW(`UHR_FIFO_AW), .CW(`UHR_CNT_W)) u_txf (
        .clk       (clk),
        .resetn    (resetn),
        .flush     (tx_flush),
        .in_data   (wdata),
        .in_valid  (hold_wr && tx_in_ready && (txf_level < tx_cap)),
        .in_ready  (tx_in_ready),
        .out_data  (txf_data),
        .out_valid (txf_valid),
        .out_ready (txf_pop),
        .level     (txf_level)
    );

    // empty flag: a free slot, set when shifter takes a byte
    assign thr_empty    = fifo_en ? (txf_level < tx_cap) : !txf_valid;
    assign tx_all_empty = !txf_valid && (tx_state_reg == TX_IDLE);
    assign txf_pop      = txf_valid && (tx_state_reg == TX_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // transmit shifter: start, 8 data lsb first, stop at 16 ticks a bit
    always @(posedge clk) begin
        if (!resetn) begin
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg   <= 4'h0;
            tx_bit_reg   <= 4'h0;
            tx_shifter   <= 10'h3FF;
            sout         <= 1'b1;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    sout <= 1'b1;
                    if (txf_pop) begin
                        tx_shifter   <= {1'b1, txf_data, 1'b0};
                        tx_state_reg <= TX_SHIFT;
                        tx_cnt_reg   <= 4'h0;
                        tx_bit_reg   <= 4'h0;
                    end
                end
                TX_SHIFT: begin
                    sout <= tx_shifter[0];
                    if (tick16) begin
                        tx_cnt_reg <= tx_cnt_reg + 4'h1;
                        if (tx_cnt_reg == `UHR_OVERSAMPLE) begin
                            tx_shifter <= {1'b1, tx_shifter[9:1]};
                            tx_bit_reg <= tx_bit_reg + 4'h1;
                            if (tx_bit_reg == 4'h9)
                                tx_state_reg <= TX_IDLE;
                        end
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive path: assembler, two-entry skid buffer, receive fifo
    uhr_rx_start u_rx (
        .clk         (clk),
        .resetn      (resetn),
        .tick16      (tick16),
        .sin         (sin),
        .char_data   (rxc_data),
        .char_valid  (rxc_valid),
        .frame_err   (rxc_fe),
        .brk_det     (rxc_bi),
        .false_start ()
    );

    // skid buffer keeps a character when the fifo is momentarily full
    uhr_fifo #(.DEPTH(2), .AW(1), .CW(2)) u_skid (
        .clk       (clk),
        .resetn    (resetn),
        .flush     (rx_flush),
        .in_data   (rxc_data),
        .in_valid  (rxc_valid),
        .in_ready  (rxc_ready),
        .out_data  (skid_data),
        .out_valid (skid_valid),
        .out_ready (skid_ready),
        .level     ()
    );

    uhr_fifo #(.DEPTH(`UHR_FIFO_DEPTH), .AW(`UHR_FIFO_AW), .CW(`UHR_CNT_W)) u_rxf (
        .clk       (clk),
        .resetn    (resetn),
        .flush     (rx_flush),
        .in_data   (skid_data),
        .in_valid  (skid_valid && (rxf_level < rx_cap)),
        .in_ready  (),
        .out_data  (rxf_data),
        .out_valid (rxf_valid),
        .out_ready (hold_rd),
        .level     (rxf_level)
    );
    assign skid_ready = (rxf_level < rx_cap);

    ////////////////////////////////////////////////////////////////////////
    // status assembly
    assign trig_hit        = fifo_en && (rxf_level >= rx_trigger);
    assign line_status_reg = {oe_reg | fe_reg | bi_reg,
                              tx_all_empty, thr_empty, bi_reg, fe_reg, 1'b0, oe_reg,
                              rxf_valid};
    assign cts_rise        = cts && !cts_last_reg;
    assign rts_rise        = rts && !rts_last_reg;
    assign rdata_next_sel  = rd_stb && gen_sel;

    ////////////////////////////////////////////////////////////////////////
    // mask, format and sticky events; set beats a clear in the same cycle
    always @(posedge clk) begin
        if (!resetn) begin
            irq_mask_reg    <= `UHR_IRQ_MASK_RST;
            line_format_reg <= `UHR_FORMAT_RST;
            cts_last_reg    <= 1'b0;
            rts_last_reg    <= 1'b0;
            cts_evt_reg     <= 1'b0;
            rts_evt_reg     <= 1'b0;
            xoff_evt_reg    <= 1'b0;
            modem_evt_reg   <= 1'b0;
            rls_evt_reg     <= 1'b0;
            oe_reg          <= 1'b0;
            fe_reg          <= 1'b0;
            bi_reg          <= 1'b0;
        end else begin
            cts_last_reg <= cts;
            rts_last_reg <= rts;
            if (wr_stb && addr == `UHR_ADDR_FORMAT)
                line_format_reg <= wdata;
            if (wr_stb && gen_sel && addr == `UHR_ADDR_IRQ_MASK)
                irq_mask_reg <= wdata;
            // reading the source register acknowledges edge events
            if (cts_rise)
                cts_evt_reg <= 1'b1;
            else if (rdata_next_sel && addr == `UHR_ADDR_SOURCE)
                cts_evt_reg <= 1'b0;
            if (rts_rise)
                rts_evt_reg <= 1'b1;
            else if (rdata_next_sel && addr == `UHR_ADDR_SOURCE)
                rts_evt_reg <= 1'b0;
            if (xoff_seen)
                xoff_evt_reg <= 1'b1;
            else if (rdata_next_sel && addr == `UHR_ADDR_SOURCE)
                xoff_evt_reg <= 1'b0;
            if (modem_chg)
                modem_evt_reg <= 1'b1;
            else if (rdata_next_sel && addr == `UHR_ADDR_SOURCE)
                modem_evt_reg <= 1'b0;
            // character arrival and errors clear on a status read
            if (rxc_valid)
                rls_evt_reg <= 1'b1;
            else if (rdata_next_sel && addr == `UHR_ADDR_STATUS)
                rls_evt_reg <= 1'b0;
            if (rxc_valid && !rxc_ready)
                oe_reg <= 1'b1;
            else if (rdata_next_sel && addr == `UHR_ADDR_STATUS)
                oe_reg <= 1'b0;
            if (rxc_valid && rxc_fe)
                fe_reg <= 1'b1;
            else if (rdata_next_sel && addr == `UHR_ADDR_STATUS)
                fe_reg <= 1'b0;
            if (rxc_valid && rxc_bi)
                bi_reg <= 1'b1;
            else if (rdata_next_sel && addr == `UHR_ADDR_STATUS)
                bi_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gated sources; receive data uses trigger in fifo mode, data ready otherwise
    always @* begin
        irq_src = 8'h00;
        irq_src[`UHR_IE_RXRDY] = irq_mask_reg[`UHR_IE_RXRDY] & (fifo_en ? trig_hit : rxf_valid);
        irq_src[`UHR_IE_THRE]  = irq_mask_reg[`UHR_IE_THRE] & thr_empty;
        irq_src[`UHR_IE_RLS]   = irq_mask_reg[`UHR_IE_RLS] & rls_evt_reg;
        irq_src[`UHR_IE_MODEM] = irq_mask_reg[`UHR_IE_MODEM] & modem_evt_reg;
        irq_src[`UHR_IE_XOFF]  = irq_mask_reg[`UHR_IE_XOFF] & xoff_evt_reg;
        irq_src[`UHR_IE_RTS]   = irq_mask_reg[`UHR_IE_RTS] & rts_evt_reg;
        irq_src[`UHR_IE_CTS]   = irq_mask_reg[`UHR_IE_CTS] & cts_evt_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs and read data
    always @(posedge clk) begin
        if (!resetn) begin
            irq         <= 1'b0;
            sleep_ok    <= 1'b0;
            rx_ready    <= 1'b0;
            rdata       <= 8'h00;
            rx_hold_reg <= 8'h00;
        end else begin
            irq      <= |irq_src;
            sleep_ok <= irq_mask_reg[`UHR_IE_SLEEP];
            rx_ready <= rxf_valid;
            if (hold_rd)
                rx_hold_reg <= rxf_data;
            if (rd_stb && addr == `UHR_ADDR_FORMAT) begin
                rdata <= line_format_reg;
            end else if (rdata_next_sel) begin
                case (addr)
                    `UHR_ADDR_HOLD:     rdata <= rxf_valid ? rxf_data : rx_hold_reg;
                    `UHR_ADDR_IRQ_MASK: rdata <= irq_mask_reg;
                    // source code: receive trigger level drives its status
                    `UHR_ADDR_SOURCE:   rdata <= (|irq_src) ? {fifo_en, fifo_en, 6'h04 & {6{trig_hit}}}
                                                            : {fifo_en, fifo_en, 6'h01};
                    `UHR_ADDR_STATUS:   rdata <= line_status_reg;
                    default:            rdata <= 8'h00;
                endcase
            end else if (rd_stb) begin
                rdata <= 8'h00;
            end
        end
    end

endmodule

// File: hdl/uhr_map.vh
/*
 * Register addresses, field positions, reset values and timing counts
 * for the holding-register and interrupt-enable block.
 * Assumes a 3-bit register address and an 8-bit data bus.
 */
`ifndef UHR_MAP_VH
`define UHR_MAP_VH

// register addresses
`define UHR_ADDR_HOLD        3'h0
`define UHR_ADDR_IRQ_MASK    3'h1
`define UHR_ADDR_SOURCE      3'h2
`define UHR_ADDR_FORMAT      3'h3
`define UHR_ADDR_STATUS      3'h5

// reset values
`define UHR_IRQ_MASK_RST     8'h00
`define UHR_FORMAT_RST       8'h00
`define UHR_SOURCE_NONE      8'h01

// irq mask bit positions
`define UHR_IE_RXRDY         0
`define UHR_IE_THRE          1
`define UHR_IE_RLS           2
`define UHR_IE_MODEM         3
`define UHR_IE_SLEEP         4
`define UHR_IE_XOFF          5
`define UHR_IE_RTS           6
`define UHR_IE_CTS           7

// line format: divisor latch enable position
`define UHR_FMT_DLAB         7

// line status bit positions
`define UHR_LS_DR            0
`define UHR_LS_OE            1
`define UHR_LS_PE            2
`define UHR_LS_FE            3
`define UHR_LS_BI            4
`define UHR_LS_THRE          5
`define UHR_LS_TEMT          6
`define UHR_LS_FERR          7

// fifo geometry
`define UHR_FIFO_DEPTH       32
`define UHR_FIFO_AW          5
`define UHR_CNT_W            6

// sample clock counts: 16 samples per bit, mid point after 7.5
`define UHR_OVERSAMPLE       4'hF
`define UHR_MID_SAMPLE       4'h7

`endif

// File: hdl/uhr_fifo.v
/*
 * Synchronous byte fifo with registered read data and valid/ready on
 * both sides. Depth given by parameter; a depth of 2 serves as skid buffer.
 * Assumes a single clock and synchronous active-low reset.
 */
module uhr_fifo #(
    parameter DEPTH = 32,
    parameter AW    = 5,
    parameter CW    = 6
) (
    input  wire          clk,       // system clock
    input  wire          resetn,    // sync reset, active low
    input  wire          flush,     // drop all contents
    input  wire [7:0]    in_data,   // write data
    input  wire          in_valid,  // write request
    output wire          in_ready,  // room for a word
    output reg  [7:0]    out_data,  // head word, registered
    output reg           out_valid, // head word present
    input  wire          out_ready, // head word consumed
    output wire [CW-1:0] level      // words held, head included
);

    reg  [7:0]    mem [0:DEPTH-1];
    reg  [AW-1:0] wr_ptr_reg;
    reg  [AW-1:0] rd_ptr_reg;
    reg  [CW-1:0] cnt_reg;
    wire          push;
    wire          pop;
    wire          load;

    ////////////////////////////////////////////////////////////////////////
    // the head register counts as a slot so level is the true fill
    assign in_ready = (cnt_reg != DEPTH[CW-1:0]);
    assign push     = in_valid & in_ready;
    assign pop      = out_valid & out_ready;
    assign level    = cnt_reg;
    // refill head when empty or being drained and memory holds a word
    assign load     = (cnt_reg > {{(CW-1){1'b0}}, out_valid}) && (!out_valid || pop);

    always @(posedge clk) begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
    end

    ////////////////////////////////////////////////////////////////////////
    // pointers, count and head register
    always @(posedge clk) begin
        if (!resetn || flush) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            cnt_reg    <= {CW{1'b0}};
            out_valid  <= 1'b0;
            out_data   <= 8'h00;
        end else begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
            if (push && !pop)
                cnt_reg <= cnt_reg + 1'b1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 1'b1;
            if (load) begin
                out_data   <= mem[rd_ptr_reg];
                out_valid  <= 1'b1;
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
            end else if (pop) begin
                out_valid <= 1'b0;
            end
        end
    end

endmodule

// File: hdl/uhr_rx_start.v
/*
 * Receive start-bit hunter and character assembler at the 16x sample
 * tick. Frames are 8 data bits, no parity, one stop bit.
 * Assumes serial input already synchronous to clk.
 */
`include "uhr_map.vh"

module uhr_rx_start (
    input  wire       clk,        // system clock
    input  wire       resetn,     // sync reset, active low
    input  wire       tick16,     // 16x bit-rate sample enable
    input  wire       sin,        // serial input
    output reg  [7:0] char_data,  // assembled character
    output reg        char_valid, // one-cycle pulse per character
    output reg        frame_err,  // stop bit low on this character
    output reg        brk_det,    // all-zero frame with low stop
    output reg        false_start // one-cycle pulse on rejected start
);

    localparam [3:0] ST_HUNT  = 4'b0001;
    localparam [3:0] ST_START = 4'b0010;
    localparam [3:0] ST_DATA  = 4'b0100;
    localparam [3:0] ST_STOP  = 4'b1000;

    reg [3:0] state_reg;
    reg [3:0] tcnt_reg;
    reg [2:0] bit_reg;
    reg [7:0] rx_shifter;
    reg       sin_last_reg;

    ////////////////////////////////////////////////////////////////////////
    // hunt, validate at mid start bit, then sample each bit centre
    always @(posedge clk) begin
        if (!resetn) begin
            state_reg    <= ST_HUNT;
            tcnt_reg     <= 4'h0;
            bit_reg      <= 3'h0;
            rx_shifter   <= 8'h00;
            sin_last_reg <= 1'b1;
            char_data    <= 8'h00;
            char_valid   <= 1'b0;
            frame_err    <= 1'b0;
            brk_det      <= 1'b0;
            false_start  <= 1'b0;
        end else begin
            char_valid  <= 1'b0;
            false_start <= 1'b0;
            if (tick16) begin
                sin_last_reg <= sin;
                case (state_reg)
                    ST_HUNT: begin
                        // falling edge starts the sample count
                        if (sin_last_reg && !sin) begin
                            state_reg <= ST_START;
                            tcnt_reg  <= 4'h0;
                        end
                    end
                    ST_START: begin
                        tcnt_reg <= tcnt_reg + 4'h1;
                        if (tcnt_reg == `UHR_MID_SAMPLE) begin
                            tcnt_reg <= 4'h0;
                            if (!sin) begin
                                state_reg <= ST_DATA;
                                bit_reg   <= 3'h0;
                            end else begin
                                // glitch: drop it, nothing assembled
                                state_reg   <= ST_HUNT;
                                false_start <= 1'b1;
                            end
                        end
                    end
                    ST_DATA: begin
                        tcnt_reg <= tcnt_reg + 4'h1;
                        if (tcnt_reg == `UHR_OVERSAMPLE) begin
                            rx_shifter <= {sin, rx_shifter[7:1]};
                            bit_reg    <= bit_reg + 3'h1;
                            if (bit_reg == 3'h7)
                                state_reg <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        tcnt_reg <= tcnt_reg + 4'h1;
                        if (tcnt_reg == `UHR_OVERSAMPLE) begin
                            state_reg  <= ST_HUNT;
                            char_data  <= rx_shifter;
                            char_valid <= 1'b1;
                            frame_err  <= !sin;
                            brk_det    <= !sin && (rx_shifter == 8'h00);
                        end
                    end
                    default: state_reg <= ST_HUNT;
                endcase
            end
        end
    end

endmodule

// File: verif/uhr_checker.sv
/* port assertions for uhr_core.
   assumes one clock, sync active-low reset. */
module uhr_checker (
    input wire logic       clk,       // clock
    input wire logic       resetn,    // reset
    input wire logic [2:0] addr,      // address
    input wire logic [7:0] wdata,     // wr data
    input wire logic       wr_stb,    // write
    input wire logic       cts,       // cts
    input wire logic       rts,       // rts
    input wire logic       xoff_seen, // xoff
    input wire logic       irq,       // irq
    input wire logic       sleep_ok,  // sleep
    input wire logic       sout,      // tx line
    input wire logic       rx_ready,  // rx data
    input wire logic [7:0] rdata      // rd data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [7:0] m_reg;  // mask shadow
    logic       dl_reg; // latch bit shadow
    //////////////////////////////////////////
    // shadows; mask writes dropped while latch bit set
    always_ff @(posedge clk) begin
        if (!resetn) begin
            m_reg  <= 8'h00;
            dl_reg <= 1'b0;
        end else if (wr_stb && addr == 3'h3) dl_reg <= wdata[7];
        else if (wr_stb && addr == 3'h1 && !dl_reg) m_reg <= wdata;
    end
    sequence s_lo8; !sout [*8]; endsequence
    property p_rst; $rose(resetn) |-> !irq && sout && !sleep_ok && !rx_ready && rdata == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_cts; $rose(cts) && m_reg[7] |-> ##[1:3] irq; endproperty
    a_cts: assert property (p_cts) else $error("cts irq missing");
    property p_rts; $rose(rts) && m_reg[6] |-> ##[1:3] irq; endproperty
    a_rts: assert property (p_rts) else $error("rts irq missing");
    property p_xoff; xoff_seen && m_reg[5] |-> ##[1:3] irq; endproperty
    a_xoff: assert property (p_xoff) else $error("xoff irq missing");
    property p_zero; (m_reg == 8'h00) [*3] |-> !irq; endproperty
    a_zero: assert property (p_zero) else $error("irq with mask clear");
    property p_slp; wr_stb && addr == 3'h1 && !dl_reg && wdata[4] |-> ##[1:2] sleep_ok; endproperty
    a_slp: assert property (p_slp) else $error("sleep not permitted");
    property p_lock; wr_stb && addr == 3'h1 && dl_reg |-> ##2 $stable(sleep_ok); endproperty
    a_lock: assert property (p_lock) else $error("mask write while locked");
    property p_start; $fell(sout) |-> s_lo8; endproperty
    a_start: assert property (p_start) else $error("start bit short");
endmodule
bind uhr_core uhr_checker ck (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .cts(cts), .rts(rts), .xoff_seen(xoff_seen), .irq(irq), .sleep_ok(sleep_ok), .sout(sout),
    .rx_ready(rx_ready), .rdata(rdata));

// File: verif/uhr_line.sv
/* serial partner: 8n1 frames on sin, lsb first.
   assumes tick16 every clock, 16 clocks a bit. */
module uhr_line (
    input  wire logic       clk,   // clock
    input  wire logic       go,    // send frame
    input  wire logic       short, // glitch only
    input  wire logic [7:0] byt,   // frame data
    output logic            sin,   // idle high
    output logic            tick16 // sample enable
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sin    = 1'b1;
        tick16 = 1'b1;
    end
    //////////////////////////////////////////
    // glitch is under half a bit, so it must be rejected
    always @(posedge go) begin
        sin <= 1'b0;
        repeat (short ? 4 : 16) @(posedge clk);
        for (int i = 0; i < 8 && !short; i++) begin
            sin <= byt[i];
            repeat (16) @(posedge clk);
        end
        sin <= 1'b1;
    end
endmodule

// File: verif/uhr_core_tb.sv
/* self-checking bench for uhr_core.
   assumes 25 MHz clock and the serial partner. */
module uhr_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, resetn = 0, wr_stb = 0, rd_stb = 0, ev = 0, go = 0, short = 0, fe = 1;
    logic sin, tick16, sout, irq, sleep_ok, rx_ready;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, byt = 8'h00, rdata;
    int errors = 0, compares = 0, cyc = 0, k;
    logic [18:0] rows [3] = '{{3'h1, 8'hFF, 8'hFF}, {3'h3, 8'h03, 8'h03}, {3'h1, 8'h10, 8'h10}};
    always #20 clk = ~clk;
    uhr_core dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .fifo_en(fe), .rx_trigger(6'h01), .rx_flush(1'b0),
        .tx_flush(1'b0), .tick16(tick16), .sin(sin), .sout(sout), .cts(ev), .rts(ev),
        .xoff_seen(ev), .modem_chg(ev), .irq(irq), .sleep_ok(sleep_ok), .rx_ready(rx_ready));
    uhr_line line (.clk(clk), .go(go), .short(short), .byt(byt), .sin(sin), .tick16(tick16));
    //////////////////////////////////////////
    task end_sim;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, s, e);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        {addr, wdata, wr_stb} <= {a, d, 1'b1};
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    // sampled on the falling edge so the answer has settled
    task rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        {addr, rd_stb} <= {a, 1'b1};
        @(posedge clk);
        rd_stb <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    task send(input logic [7:0] b, input logic s);
        @(posedge clk);
        {byt, short, go} <= {b, s, 1'b1};
        @(posedge clk);
        go <= 1'b0;
        repeat (200) @(negedge clk);
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            end_sim;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rd(3'h5, 8'h60);
        rd(3'h1, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i][18:16], rows[i][15:8]);
            rd(rows[i][18:16], rows[i][7:0]);
        end
        chk({7'h00, sleep_ok}, 8'h01);
        wr(3'h3, 8'h80);
        wr(3'h1, 8'h01);
        wr(3'h3, 8'h00);
        rd(3'h1, 8'h10);
        $display("test registers done");
        wr(3'h1, 8'hE8);
        @(posedge clk);
        ev <= 1'b1;
        @(posedge clk);
        ev <= 1'b0;
        repeat (4) @(negedge clk);
        chk({7'h00, irq}, 8'h01);
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h5A);
        for (k = 0; k < 40 && sout === 1'b1; k++) @(negedge clk);
        repeat (8) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(negedge clk);
            chk({7'h00, sout}, (8'h5A >> i) & 8'h01);
        end
        $display("test transmit done");
        send(8'hC3, 1'b0);
        send(8'h3C, 1'b0);
        chk({7'h00, rx_ready}, 8'h01);
        rd(3'h0, 8'hC3);
        rd(3'h0, 8'h3C);
        repeat (4) @(negedge clk);
        chk({7'h00, rx_ready}, 8'h00);
        send(8'h00, 1'b1);
        chk({7'h00, rx_ready}, 8'h00);
        @(posedge clk) fe <= 1'b0;
        rd(3'h2, 8'h01);
        $display("test receive done");
        end_sim;
    end
endmodule
